//--- core/scsi_core.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// (RULE_01) software confirms reception done before switching to transmit
// (RULE_02) software confirms transmit end before switching to receive
// (RULE_03) gsm mode lets the two clock bits fix the clock output level
// (RULE_04) only tx-empty, error and rx-full interrupts; no tx-end interrupt
// (RULE_05) tx-empty request follows transmit end flag gated by tx enable
// (RULE_06) rx-full request follows receive full flag gated by rx enable
// (RULE_07) error request from overrun, parity or error-signal flag, rx gate
// (RULE_08) software standby entry sequence is the software's duty
// (RULE_09) clearing clock enable finishes current period then holds level; the code stops the clock in gsm mode only, outside it the clock keeps running
// (RULE_10) on restart clock resumes with normal duty
// (RULE_11) after power-on software fixes level then enables clock
// (RULE_12) each bit lasts 372 base clock ticks
// (RULE_13) align on start bit fall, latch bits at tick 186
// (RULE_14) a character frame spans ten bit periods
// (RULE_15) parity mismatch sets parity error flag
// (RULE_16) a frame with parity error does not set receive full
// (RULE_17) good parity sets receive full flag
// (RULE_18) after a good frame the data line stays released in error slot
// (RULE_19) error signal from card sets the error-signal flag
// (RULE_20) a frame answered by error signal does not set transmit end
// (RULE_21) no error signal sets transmit end
// (RULE_22) only character t=0 exchange, no block transfers
// (RULE_23) a character with parity error still lands in receive data
// (RULE_24) card enable turns the data pin to serial use, released
// (RULE_25) on parity error drive line low in error slot
// (RULE_26) on returned error signal resend the same character
module scsi_core
  import scsi_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        data_in,
  output logic             data_out,
  output logic             data_oe,
  output logic             card_clock_port_pin,
  output logic             card_clock_oe,
  output logic             tx_empty_interrupt,
  output logic             rx_full_interrupt,
  output logic             error_interrupt
);

  // ****************************************
  // register bus
  // ****************************************
  logic [7:0]  serial_mode_register;
  logic [7:0]  serial_control_register;
  logic [7:0]  card_mode_register;
  logic [7:0]  bit_divider;
  logic [7:0]  tx_data;
  logic [7:0]  receive_data_register;
  logic        tdre, receive_full_flag, overrun_flag, error_signal_flag, parity_flag, transmit_end_flag;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        rd_ok;
  logic [7:0]  rd_addr;
  logic [7:0]  status_now;

  // response is single-cycle and always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  assign rd_ok = hsel && hready && htrans[1] && !hwrite;
  assign rd_addr = haddr[7:0];
  assign status_now = {tdre, receive_full_flag, overrun_flag, error_signal_flag, parity_flag, transmit_end_flag, 2'b00};

  // read data registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (rd_ok) begin
      unique case (rd_addr)
        OFS_MODE:    hrdata <= {24'h000000, serial_mode_register};
        OFS_CONTROL: hrdata <= {24'h000000, serial_control_register};
        OFS_STATUS:  hrdata <= {24'h000000, status_now};
        OFS_TXDATA:  hrdata <= {24'h000000, tx_data};
        OFS_RXDATA:  hrdata <= {24'h000000, receive_data_register};
        OFS_CARD:    hrdata <= {16'h0000, bit_divider, card_mode_register};
        OFS_IRQ:     hrdata <= {29'h00000000, tx_empty_interrupt, rx_full_interrupt, error_interrupt};
        default:     hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_mode_register <= RESET_MODE;
      serial_control_register <= RESET_CONTROL;
      card_mode_register <= 8'h00;
      bit_divider <= DIV_DEFAULT;
      tx_data <= 8'h00;
    end else if (wr_pend) begin
      if (wr_addr == OFS_MODE) serial_mode_register <= hwdata[7:0];
      if (wr_addr == OFS_CONTROL) serial_control_register <= hwdata[7:0];
      if (wr_addr == OFS_CARD) begin
        card_mode_register <= hwdata[7:0];
        bit_divider <= hwdata[15:8];
      end
      if (wr_addr == OFS_TXDATA) tx_data <= hwdata[7:0];
    end
  end

  logic sw_wr_status;
  logic sw_wr_tx;
  assign sw_wr_status = wr_pend && (wr_addr == OFS_STATUS);
  assign sw_wr_tx = wr_pend && (wr_addr == OFS_TXDATA);

  // ****************************************
  // base clock and card clock
  // ****************************************
  logic [7:0]  div_cnt;
  logic        base_tick;
  logic        clk_phase;
  logic        clk_running;
  logic        card_en;
  logic        gsm;
  assign card_en = card_mode_register[CARD_EN];
  assign gsm = serial_mode_register[MODE_GSM];

  // base tick is a one-cycle enable; card clock runs at half the base tick rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 8'h00;
      base_tick <= 1'b0;
    end else if (div_cnt == bit_divider) begin
      div_cnt <= 8'h00;
      base_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      base_tick <= 1'b0;
    end
  end

  // card clock toggles each base tick; a stop waits for the phase to end so no
  // runt pulse reaches the card
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_phase <= 1'b0;
      clk_running <= 1'b0;
    end else if (base_tick) begin
      if (clk_running) begin
        clk_phase <= ~clk_phase;
        if (clk_phase && !serial_control_register[CTL_CKOE] && gsm)
          clk_running <= 1'b0; // RULE_09
      end else if (serial_control_register[CTL_CKOE] && card_en) begin
        clk_running <= 1'b1; // RULE_10
        clk_phase <= 1'b0;
      end
    end
  end

  // fixed level from clock_level_select when stopped in gsm mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_clock_port_pin <= 1'b0;
      card_clock_oe <= 1'b0;
    end else begin
      card_clock_oe <= card_en && (serial_control_register[CTL_CKOE] || clk_running || gsm);
      if (clk_running)
        card_clock_port_pin <= clk_phase;
      else
        card_clock_port_pin <= serial_control_register[CTL_CKLVL]; // RULE_03
    end
  end

  // ****************************************
  // character engine
  // ****************************************
  logic           din_meta, din_sync, din_prev;
  scsi_state_type state;
  logic [8:0]     tick_cnt;
  logic [3:0]     bit_idx;
  logic [8:0]     shreg;
  logic           parity_acc;
  logic           tx_mode;
  logic           tx_busy;
  logic           bad_rx;
  logic           err_seen;

  // two-flop synchroniser on the data pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_meta <= 1'b1;
      din_sync <= 1'b1;
      din_prev <= 1'b1;
    end else begin
      din_meta <= data_in;
      din_sync <= din_meta;
      din_prev <= din_sync;
    end
  end

  // data register empties when a frame or a resend loads the shifter; a write in that cycle keeps it full
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tdre <= 1'b1;
    else if (sw_wr_tx)
      tdre <= 1'b0;
    else if (card_en && state == SCSI_IDLE && serial_control_register[CTL_TE] && base_tick)
      tdre <= 1'b1;
  end

  // frame sequencer: start, 8 data, parity, error slot, guard
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SCSI_IDLE;
      tick_cnt <= 9'h000;
      bit_idx <= 4'h0;
      shreg <= 9'h000;
      parity_acc <= 1'b0;
      tx_mode <= 1'b0;
      tx_busy <= 1'b0;
      bad_rx <= 1'b0;
      err_seen <= 1'b0;
      data_out <= 1'b1;
      data_oe <= 1'b0; // RULE_24
    end else if (!card_en) begin
      state <= SCSI_IDLE;
      data_oe <= 1'b0;
      tx_busy <= 1'b0;
    end else begin
      unique case (state)
        SCSI_IDLE: begin
          data_oe <= 1'b0;
          tick_cnt <= 9'h000;
          bit_idx <= 4'h0;
          if (serial_control_register[CTL_TE] && (!tdre || tx_busy) && base_tick) begin
            tx_mode <= 1'b1;
            tx_busy <= 1'b1;
            shreg <= {^tx_data ^ serial_mode_register[MODE_ODD], tx_data}; // RULE_26
            data_out <= 1'b0;
            data_oe <= 1'b1;
            state <= SCSI_DATA;
          end else if (serial_control_register[CTL_RE] && din_prev && !din_sync) begin
            tx_mode <= 1'b0; // RULE_13
            parity_acc <= serial_mode_register[MODE_ODD];
            state <= SCSI_DATA;
          end
        end
        SCSI_DATA: if (base_tick) begin
          if (tick_cnt == 9'(BASE_PER_BIT - 1)) begin // RULE_12
            tick_cnt <= 9'h000;
            bit_idx <= bit_idx + 4'h1;
            if (tx_mode) begin
              data_out <= shreg[0];
              shreg <= {1'b1, shreg[8:1]};
            end
            if (bit_idx == 4'(FRAME_BITS - 1)) begin // RULE_14
              data_oe <= 1'b0; // RULE_18
              state <= SCSI_ERRSLOT;
              bit_idx <= 4'h0;
              if (!tx_mode && bad_rx) begin
                data_out <= 1'b0; // RULE_25
                data_oe <= 1'b1;
              end
            end
          end else begin
            tick_cnt <= tick_cnt + 9'h001;
          end
          if (!tx_mode && bit_idx != 4'h0 && tick_cnt == 9'(SAMPLE_TICK - 1)) begin
            shreg <= {din_sync, shreg[8:1]}; // RULE_13
            parity_acc <= parity_acc ^ din_sync;
            if (bit_idx == 4'(FRAME_BITS - 1))
              bad_rx <= parity_acc ^ din_sync;
          end
        end
        SCSI_ERRSLOT: if (base_tick) begin
          if (tx_mode && tick_cnt == 9'(BASE_PER_BIT / 2))
            err_seen <= !din_sync;
          if (tick_cnt == 9'(BASE_PER_BIT - 1)) begin
            tick_cnt <= 9'h000;
            data_oe <= 1'b0;
            data_out <= 1'b1;
            state <= SCSI_GUARD;
          end else begin
            tick_cnt <= tick_cnt + 9'h001;
          end
        end
        SCSI_GUARD: if (base_tick) begin
          if (tick_cnt == 9'(BASE_PER_BIT - 1)) begin
            tick_cnt <= 9'h000;
            state <= SCSI_IDLE;
            bad_rx <= 1'b0;
            err_seen <= 1'b0;
            if (tx_mode && !err_seen)
              tx_busy <= 1'b0; // RULE_21
          end else begin
            tick_cnt <= tick_cnt + 9'h001;
          end
        end
      endcase
    end
  end

  // ****************************************
  // status flags; a hardware set wins over a software clear
  // ****************************************
  logic rx_done, tx_done_ok, tx_done_err;
  assign rx_done = card_en && base_tick && state == SCSI_ERRSLOT && !tx_mode && tick_cnt == 9'h000;
  assign tx_done_ok = card_en && base_tick && state == SCSI_GUARD && tx_mode && !err_seen
                      && tick_cnt == 9'(BASE_PER_BIT - 1);
  assign tx_done_err = card_en && base_tick && state == SCSI_GUARD && tx_mode && err_seen
                       && tick_cnt == 9'h000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receive_full_flag <= 1'b0;
      overrun_flag <= 1'b0;
      parity_flag <= 1'b0;
      error_signal_flag <= 1'b0;
      transmit_end_flag <= 1'b1;
      receive_data_register <= 8'h00;
    end else begin
      if (sw_wr_status) begin
        if (!hwdata[ST_RECEIVE_FULL_FLAG]) receive_full_flag <= 1'b0;
        if (!hwdata[ST_OVERRUN_FLAG]) overrun_flag <= 1'b0;
        if (!hwdata[ST_PER])  parity_flag <= 1'b0;
        if (!hwdata[ST_ERS])  error_signal_flag <= 1'b0;
      end
      if (sw_wr_tx)
        transmit_end_flag <= 1'b0;
      if (rx_done) begin
        receive_data_register <= shreg[7:0]; // RULE_23
        if (bad_rx)
          parity_flag <= 1'b1; // RULE_15 RULE_16
        else if (receive_full_flag && !(sw_wr_status && !hwdata[ST_RECEIVE_FULL_FLAG]))
          overrun_flag <= 1'b1;
        else
          receive_full_flag <= 1'b1; // RULE_17
      end
      if (tx_done_err)
        error_signal_flag <= 1'b1; // RULE_19 RULE_20
      if (tx_done_ok)
        transmit_end_flag <= 1'b1; // RULE_21
    end
  end

  // three requests only; no transmit-end request exists (RULE_22: t=0 only)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_empty_interrupt <= 1'b0;
      rx_full_interrupt <= 1'b0;
      error_interrupt <= 1'b0;
    end else begin
      tx_empty_interrupt <= transmit_end_flag && serial_control_register[CTL_TIE]; // RULE_04 RULE_05
      rx_full_interrupt <= receive_full_flag && serial_control_register[CTL_RIE]; // RULE_06
      error_interrupt <= (overrun_flag || parity_flag || error_signal_flag)
                         && serial_control_register[CTL_RIE]; // RULE_07
    end
  end

endmodule
`default_nettype wire

//--- core/scsi_pkg.sv
package scsi_pkg;

  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] OFS_MODE    = 8'h00; // serial_mode_register
  localparam logic [7:0] OFS_CONTROL = 8'h04; // serial_control_register
  localparam logic [7:0] OFS_STATUS  = 8'h08; // serial_status_register
  localparam logic [7:0] OFS_TXDATA  = 8'h0c;
  localparam logic [7:0] OFS_RXDATA  = 8'h10; // receive_data_register
  localparam logic [7:0] OFS_CARD    = 8'h14; // card_mode_register
  localparam logic [7:0] OFS_IRQ     = 8'h18; // live interrupt requests

  // serial_mode_register fields
  localparam int MODE_GSM    = 7; // gsm_mode_bit
  localparam int MODE_ODD    = 4; // odd parity when 1
  // serial_control_register fields
  localparam int CTL_TIE     = 7;
  localparam int CTL_RIE     = 6;
  localparam int CTL_TE      = 5;
  localparam int CTL_RE      = 4;
  localparam int CTL_CKLVL   = 1; // clock_level_select
  localparam int CTL_CKOE    = 0; // clock_output_enable
  // serial_status_register fields
  localparam int ST_TDRE     = 7;
  localparam int ST_RECEIVE_FULL_FLAG     = 6;
  localparam int ST_OVERRUN_FLAG     = 5;
  localparam int ST_ERS      = 4;
  localparam int ST_PER      = 3;
  localparam int ST_TRANSMIT_END_FLAG     = 2;
  // card_mode_register fields
  localparam int CARD_EN     = 0; // card_interface_enable

  localparam logic [7:0] RESET_MODE    = 8'h00;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_STATUS  = 8'h84;

  // bit timing in base-clock ticks
  localparam int BASE_PER_BIT   = 372;
  localparam int SAMPLE_TICK    = 186;
  localparam int FRAME_BITS     = 10;
  localparam int GUARD_BITS     = 2;   // error-signal slot plus guard
  localparam logic [7:0] DIV_DEFAULT = 8'h00; // base clock divider reload

  typedef enum logic [2:0] {SCSI_IDLE, SCSI_DATA, SCSI_ERRSLOT, SCSI_GUARD} scsi_state_type;

endpackage

//--- tb/scsi_card_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// card on the shared data line
// ********
module scsi_card_model #(
  parameter int BIT_CYC = 744
)
(
  input  wire logic hclk,
  input  wire logic data_out,
  input  wire logic data_oe,
  output logic      line
);
  logic       drv_low   = 1'b0;
  logic       sending   = 1'b0;
  logic       nack_seen = 1'b0;
  logic [7:0] last_byte = 8'h00;
  int         n_rx      = 0;
  int         n_nack    = 0;
  int         nack_cnt  = 0;

  // open-drain wire with pull-up: nobody pulling low reads high
  assign line = !((data_oe && !data_out) || drv_low);

  // send one character, even parity unless told to spoil it
  task send_char(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    f = {(^b) ^ bad, b, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 10; i++) begin
      drv_low <= !f[i];
      repeat (BIT_CYC) @(posedge hclk);
    end
    drv_low <= 1'b0;
    repeat (BIT_CYC / 2) @(posedge hclk);
    nack_seen = !line;
    repeat (BIT_CYC * 3 / 2) @(posedge hclk);
    sending = 1'b0;
  endtask

  // receive; guard is cut short so a prompt resend is not missed
  always begin : rx_proc
    logic [8:0] f;
    @(negedge line);
    if (!sending) begin
      repeat (BIT_CYC / 2) @(posedge hclk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge hclk);
        f[i] = line;
      end
      last_byte = f[7:0];
      repeat (BIT_CYC / 2) @(posedge hclk);
      if (nack_cnt > 0) begin
        nack_cnt = nack_cnt - 1;
        drv_low <= 1'b1;
        repeat (BIT_CYC) @(posedge hclk);
        drv_low <= 1'b0;
        n_nack = n_nack + 1;
      end
      repeat (BIT_CYC / 2) @(posedge hclk);
      n_rx = n_rx + 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/scsi_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// port checker
// ********
module scsi_core_asserts
  import scsi_pkg::*;
#(
  parameter int TICK_CYC = 2,
  parameter int BIT_CYC  = 744
)
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        data_out,
  input wire logic        data_oe,
  input wire logic        card_clock_port_pin,
  input wire logic        card_clock_oe,
  input wire logic        tx_empty_interrupt,
  input wire logic        rx_full_interrupt,
  input wire logic        error_interrupt
);
  logic        ap_rd, ap_wr, ck_q, out_q;
  logic [7:0]  ap_a, ctl, ck_run;
  logic [15:0] bit_run;
  wire         st_rd = ap_rd && ap_a == OFS_STATUS;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // bus phase tracking; the control copy gives the interrupt gates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_rd <= 1'b0;
      ap_wr <= 1'b0;
      ap_a  <= 8'h00;
      ctl   <= 8'h00;
    end else begin
      ap_rd <= hsel && hready && htrans[1] && !hwrite;
      ap_wr <= hsel && hready && htrans[1] && hwrite;
      ap_a  <= haddr[7:0];
      if (ap_wr && ap_a == OFS_CONTROL) begin
        ctl <= hwdata[7:0];
      end
    end
  end

  // hold counters saturate so a long idle stays legal
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_q    <= 1'b0;
      out_q   <= 1'b1;
      ck_run  <= 8'h00;
      bit_run <= 16'h0000;
    end else begin
      ck_q    <= card_clock_port_pin;
      out_q   <= data_out;
      ck_run  <= (card_clock_port_pin != ck_q) ? 8'h01 : ((ck_run == 8'hff) ? ck_run : ck_run + 8'h01);
      bit_run <= (data_out != out_q) ? 16'h0001 : ((bit_run == 16'hffff) ? bit_run : bit_run + 16'h0001);
    end
  end

  sequence tx_start_s;
    $rose(data_oe) && ctl[CTL_TE];
  endsequence
  sequence nack_s;
    $rose(data_oe) && ctl[CTL_RE] && !ctl[CTL_TE];
  endsequence

  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  tx_irq_a: assert property (st_rd && ctl[CTL_TIE] && hrdata[ST_TRANSMIT_END_FLAG] |-> ##[0:1] tx_empty_interrupt)
    else $error("tx empty request missing");
  tx_gate_a: assert property (st_rd && !ctl[CTL_TIE] |-> !tx_empty_interrupt)
    else $error("tx request without enable");
  rx_irq_a: assert property (st_rd && ctl[CTL_RIE] && hrdata[ST_RECEIVE_FULL_FLAG] |-> ##[0:1] rx_full_interrupt)
    else $error("rx full request missing");
  err_irq_a: assert property (st_rd && ctl[CTL_RIE] &&
    (hrdata[ST_OVERRUN_FLAG] || hrdata[ST_ERS] || hrdata[ST_PER]) |-> ##[0:1] error_interrupt)
    else $error("error request missing");
  irq_gate_a: assert property (st_rd && !ctl[CTL_RIE] |-> !error_interrupt && !rx_full_interrupt)
    else $error("rx side request without enable");
  nack_low_a: assert property (ctl[CTL_RE] && !ctl[CTL_TE] && data_oe |-> !data_out)
    else $error("receiver drove line high");
  nack_len_a: assert property (nack_s |=> (data_oe && !data_out) [*8]) else $error("error signal too short");
  start_low_a: assert property (tx_start_s |=> (!data_out) [*8]) else $error("start bit not low");
  bit_len_a: assert property ((data_out != out_q) && data_oe && $past(data_oe) |-> bit_run >= BIT_CYC)
    else $error("bit shorter than its period");
  clk_width_a: assert property ((card_clock_port_pin != ck_q) && $past(card_clock_oe) |-> ck_run >= TICK_CYC)
    else $error("card clock pulse too short");
endmodule

bind scsi_core scsi_core_asserts #(.TICK_CYC(2), .BIT_CYC(744)) u_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .data_out(data_out), .data_oe(data_oe), .card_clock_port_pin(card_clock_port_pin),
  .card_clock_oe(card_clock_oe), .tx_empty_interrupt(tx_empty_interrupt),
  .rx_full_interrupt(rx_full_interrupt), .error_interrupt(error_interrupt)
);
`default_nettype wire

//--- tb/scsi_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// register level bench
// ********
module scsi_core_tb
  import scsi_pkg::*;
;
  localparam int BIT_CYC = 744; // divider 1: two clocks per base tick
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        data_in, data_out, data_oe, ck_pin, ck_oe, irq_tx, irq_rx, irq_err;
  int          n_errors, check_count, k0;
  int          oe_cycles = 0;

  scsi_core u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .card_clock_port_pin(ck_pin), .card_clock_oe(ck_oe), .tx_empty_interrupt(irq_tx),
    .rx_full_interrupt(irq_rx), .error_interrupt(irq_err)
  );
  scsi_card_model #(.BIT_CYC(BIT_CYC)) u_card (.hclk(hclk), .data_out(data_out), .data_oe(data_oe), .line(data_in));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // count cycles the device drives the line
  always @(posedge hclk) begin
    if (data_oe === 1'b1) oe_cycles <= oe_cycles + 1;
  end

  task tally_and_finish;
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // wait for hready at an edge, bounded
  task wait_ready;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_errors++;
        tally_and_finish;
      end
      @(posedge hclk);
    end
  endtask

  // one single word transfer; read data lands in v
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    wait_ready;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready;
    v = hrdata;
  endtask

  task rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    ahb(1'b0, a, 32'h0);
    chk({24'h0, v[7:0] & m}, {24'h0, e});
  endtask

  task wait_card(input int r, input int n);
    int k;
    k = 0;
    while ((u_card.n_rx < r || u_card.n_nack < n) && k < 40000) begin
      @(posedge hclk);
      k++;
    end
    if (k >= 40000) begin
      n_errors++;
      tally_and_finish;
    end
  endtask

  // main sequence: reset values, receive, transmit, clock stop
  initial begin
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'b010;
    n_errors = 0;
    check_count = 0;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(OFS_MODE, 8'hff, RESET_MODE);
    rdchk(OFS_CONTROL, 8'hff, RESET_CONTROL);
    rdchk(OFS_STATUS, 8'hff, RESET_STATUS);
    chk(32'(ck_oe), 32'h0);
    ahb(1'b1, 8'h1c, 32'hff);
    rdchk(8'h1c, 8'hff, 8'h00);
    ahb(1'b1, OFS_CARD, 32'h101);
    ahb(1'b1, OFS_CONTROL, 32'h01);
    ahb(1'b1, OFS_CONTROL, 32'h51);
    chk(32'(ck_oe), 32'h1);
    chk(32'(data_oe), 32'h0);
    k0 = oe_cycles;
    u_card.send_char(8'h3b, 1'b0);
    chk(32'(oe_cycles - k0), 32'h0);
    rdchk(OFS_STATUS, 8'hff, 8'hc4);
    chk(32'(irq_rx), 32'h1);
    rdchk(OFS_RXDATA, 8'hff, 8'h3b);
    ahb(1'b1, OFS_STATUS, 32'hbf);
    u_card.send_char(8'h5a, 1'b1);
    chk(32'(u_card.nack_seen), 32'h1);
    rdchk(OFS_STATUS, 8'hff, 8'h8c);
    chk(32'(irq_err), 32'h1);
    rdchk(OFS_RXDATA, 8'hff, 8'h5a);
    ahb(1'b1, OFS_CONTROL, 32'h11);
    repeat (2) @(posedge hclk);
    chk(32'(irq_err), 32'h0);
    ahb(1'b1, OFS_STATUS, 32'hf7);
    ahb(1'b1, OFS_CONTROL, 32'he1);
    ahb(1'b1, OFS_TXDATA, 32'ha5);
    wait_card(1, 0);
    // tx end only lands when the guard bit closes, 1.5 bits after the card's count
    repeat (BIT_CYC * 2) @(posedge hclk);
    chk(32'(u_card.last_byte), 32'ha5);
    rdchk(OFS_STATUS, 8'hff, 8'h84);
    chk(32'(irq_tx), 32'h1);
    u_card.nack_cnt = 1;
    ahb(1'b1, OFS_TXDATA, 32'hc3);
    wait_card(2, 1);
    repeat (20) @(posedge hclk);
    rdchk(OFS_STATUS, 8'h14, 8'h10);
    chk(32'(irq_err), 32'h1);
    chk(32'(irq_tx), 32'h0);
    wait_card(3, 1);
    repeat (BIT_CYC * 2) @(posedge hclk);
    chk(32'(u_card.last_byte), 32'hc3);
    rdchk(OFS_STATUS, 8'h14, 8'h14);
    ahb(1'b1, OFS_STATUS, 32'hef);
    ahb(1'b1, OFS_MODE, 32'h80);
    ahb(1'b1, OFS_CONTROL, 32'h03);
    ahb(1'b1, OFS_CONTROL, 32'h02);
    repeat (8) @(posedge hclk);
    for (int i = 0; i < 4; i++) begin
      chk(32'(ck_pin), 32'h1);
      repeat (3) @(posedge hclk);
    end
    ahb(1'b1, OFS_CONTROL, 32'h00);
    repeat (8) @(posedge hclk);
    chk(32'(ck_pin), 32'h0);
    ahb(1'b1, OFS_CONTROL, 32'h01);
    repeat (8) @(posedge hclk);
    k0 = 32'(ck_pin);
    repeat (2) @(posedge hclk);
    chk(32'(ck_pin), 32'(!k0[0]));
    tally_and_finish;
  end
endmodule
`default_nettype wire
